// file: core/dac_ctrl_pkg.sv
// Constants for the quad converter output control block
package dac_ctrl_pkg;
  localparam int CORES = 4;
  localparam int CODE_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_W = 12;
  // Register addresses
  localparam logic [11:0] A_IFACE = 12'h000;
  localparam logic [11:0] A_POWER = 12'h011;
  localparam logic [11:0] A_GAIN0 = 12'h040;
  localparam logic [11:0] A_GAIN1 = 12'h041;
  localparam logic [11:0] A_GAIN2 = 12'h042;
  localparam logic [11:0] A_GAIN3 = 12'h043;
  localparam logic [11:0] A_MODE = 12'h04a;
  localparam logic [11:0] A_CLKPWR = 12'h080;
  localparam logic [11:0] A_TRX = 12'h081;
  localparam logic [11:0] A_DPA = 12'h12d;
  localparam logic [11:0] A_TEMP_EN = 12'h12f;
  localparam logic [11:0] A_TEMP_LO = 12'h132;
  localparam logic [11:0] A_TEMP_HI = 12'h133;
  localparam logic [11:0] A_CAPTURE = 12'h134;
  localparam logic [11:0] A_DPB = 12'h146;
  localparam logic [11:0] A_LINK = 12'h333;
  // Reset values
  localparam logic [7:0] RST_IFACE = 8'h00;
  localparam logic [7:0] RST_POWER = 8'hff;
  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CLKPWR = 8'h80;
  localparam logic [7:0] RST_TRX = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Field positions
  localparam int B_SOFT_HI = 7;
  localparam int B_SOFT_LO = 0;
  localparam int B_4WIRE_HI = 4;
  localparam int B_4WIRE_LO = 3;
  localparam int B_PD_REF = 7;
  localparam int B_PD_CORE0 = 3;
  localparam int B_PD_MASTER = 2;
  localparam int B_CLK_PD = 7;
  localparam int B_DCC = 2;
  localparam int B_TRX_PD = 0;
  localparam int B_TRX_HYST = 1;
  localparam int B_MIX = 0;
  localparam int B_TEMP_EN = 0;
  localparam int B_CAPTURE = 0;
  localparam logic [7:0] CLK_OTHER_MASK = 8'h7b;
  // Serial port framing
  localparam logic [4:0] INSTR_LAST = 5'h0f;
  localparam logic [4:0] DATA_FIRST = 5'h10;
  localparam logic [4:0] DATA_LAST = 5'h17;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_INSTR = 2'b01,
    PH_DATA = 2'b10
  } spi_phase_t;
endpackage

// file: core/quad_dac_output_control.sv
// Output control, register port and sample path of the quad converter
`timescale 1ns/100ps

module sample_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // Drain side
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr];
  always_comb begin
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
    end else if (flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      in_ready_out <= next_count != (AW+1)'(DEPTH);
      out_valid_out <= next_count != '0;
    end
  end
endmodule

// Operation
// R1 - Output mode comes from bit 0 of the mode register; normal after reset.
// R2 - Mode bit 0 means normal mode, 1 means mix mode.
// R3 - Normal mode presents each sample unchanged in both half cycles.
// R4 - Mix mode presents the sample first, then its inverse, same cycle.
// R5 - Each of four cores takes a continuous stream of unsigned 16-bit codes.
// R6 - All ones gives full positive current; negative output carries the complement.
// R7 - Cores 0 and 2 are in-phase, cores 1 and 3 quadrature.
// R8 - Four gain registers hold pair gains and drive output current scaling.
// R9 - Host enables the temperature sensor before trusting readback.
// R10 - Capture write latches a fresh temperature code into two readback registers.
// R11 - Writing 0xbd enters soft reset; 0x3c releases it, four-wire port.
// R12 - Zero in power control enables reference, all channels and master.
// R13 - Writing 0x04 to clock power powers all clocks with duty correction.
// R14 - Zero in timing receiver control powers it up, hysteresis off.
// R15 - Host writes mandatory datapath and link configuration values at start-up.
// R16 - Host starts interface, power, clocks, datapath, transport, phy, link, checks.
// R17 - Host uses quick link bring-up only for fast start or debug.
module quad_dac_output_control (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Serial configuration port
  input wire logic spi_cs_n_in,
  input wire logic spi_clk_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_n_out,
  // Sample stream, core 0 in the low bits
  input wire logic [63:0] core_input_code_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  // Die temperature sensor
  input wire logic [15:0] temp_sensor_in,
  output logic temp_sensor_enable_out,
  // Core half-cycle codes, gains and mode
  output logic [63:0] rise_code_out,
  output logic [63:0] fall_code_out,
  output logic [63:0] rise_comp_out,
  output logic [63:0] fall_comp_out,
  output logic [31:0] core_gain_out,
  output logic mix_mode_out,
  // Power and clock controls
  output logic soft_reset_out,
  output logic reference_enable_out,
  output logic master_enable_out,
  output logic [3:0] core_enable_out,
  output logic clocks_enable_out,
  output logic duty_correction_out,
  output logic timing_rx_enable_out,
  output logic timing_rx_hysteresis_out
);
  logic [7:0] iface_cfg;
  logic [7:0] power_ctl;
  logic [7:0] gain_word [4];
  logic [7:0] mode_sel;
  logic [7:0] clk_pwr;
  logic [7:0] trx_ctl;
  logic [7:0] dp_cfg_a;
  logic [7:0] dp_cfg_b;
  logic [7:0] link_cfg;
  logic [7:0] temp_en;
  logic [15:0] temp_code;
  logic soft_rst;
  logic four_wire;
  logic running;
  // Serial port state
  dac_ctrl_pkg::spi_phase_t phase;
  logic sclk_q;
  logic [4:0] bit_cnt;
  logic [14:0] instr_sr;
  logic [6:0] wdata_sr;
  logic [7:0] rdata_sr;
  logic rd_mode;
  logic [11:0] cur_addr;
  logic wr_stb;
  logic [11:0] wr_addr;
  logic [7:0] wr_data;
  logic sclk_rise;
  logic sclk_fall;
  logic [15:0] full_instr;
  logic [63:0] fifo_data;
  logic fifo_valid;

  assign soft_rst = iface_cfg[dac_ctrl_pkg::B_SOFT_HI] && iface_cfg[dac_ctrl_pkg::B_SOFT_LO]; // R11
  assign four_wire = iface_cfg[dac_ctrl_pkg::B_4WIRE_HI] && iface_cfg[dac_ctrl_pkg::B_4WIRE_LO];
  assign sclk_rise = !spi_cs_n_in && spi_clk_in && !sclk_q;
  assign sclk_fall = !spi_cs_n_in && !spi_clk_in && sclk_q;
  assign full_instr = {instr_sr, spi_sdi_in};

  function automatic logic [7:0] read_reg(input logic [11:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      dac_ctrl_pkg::A_IFACE: v = iface_cfg;
      dac_ctrl_pkg::A_POWER: v = power_ctl;
      dac_ctrl_pkg::A_GAIN0: v = gain_word[0];
      dac_ctrl_pkg::A_GAIN1: v = gain_word[1];
      dac_ctrl_pkg::A_GAIN2: v = gain_word[2];
      dac_ctrl_pkg::A_GAIN3: v = gain_word[3];
      dac_ctrl_pkg::A_MODE: v = mode_sel;
      dac_ctrl_pkg::A_CLKPWR: v = clk_pwr;
      dac_ctrl_pkg::A_TRX: v = trx_ctl;
      dac_ctrl_pkg::A_DPA: v = dp_cfg_a;
      dac_ctrl_pkg::A_TEMP_EN: v = temp_en;
      dac_ctrl_pkg::A_TEMP_LO: v = temp_code[7:0];
      dac_ctrl_pkg::A_TEMP_HI: v = temp_code[15:8];
      dac_ctrl_pkg::A_DPB: v = dp_cfg_b;
      dac_ctrl_pkg::A_LINK: v = link_cfg;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Serial clock edge history
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= spi_clk_in;
    end
  end

  // Frame decode: 16-bit instruction, then bytes with rising address
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase <= dac_ctrl_pkg::PH_IDLE;
      bit_cnt <= '0;
      instr_sr <= '0;
      wdata_sr <= '0;
      rd_mode <= 1'b0;
      cur_addr <= '0;
      wr_stb <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      wr_stb <= 1'b0;
      if (spi_cs_n_in) begin
        phase <= dac_ctrl_pkg::PH_IDLE;
        bit_cnt <= '0;
      end else if (sclk_rise) begin
        unique case (phase)
          dac_ctrl_pkg::PH_IDLE, dac_ctrl_pkg::PH_INSTR: begin
            instr_sr <= full_instr[14:0];
            bit_cnt <= bit_cnt + 5'h01;
            phase <= dac_ctrl_pkg::PH_INSTR;
            if (bit_cnt == dac_ctrl_pkg::INSTR_LAST) begin
              rd_mode <= full_instr[15];
              cur_addr <= full_instr[11:0];
              phase <= dac_ctrl_pkg::PH_DATA;
            end
          end
          dac_ctrl_pkg::PH_DATA: begin
            wdata_sr <= {wdata_sr[5:0], spi_sdi_in};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == dac_ctrl_pkg::DATA_LAST) begin
              bit_cnt <= dac_ctrl_pkg::DATA_FIRST;
              cur_addr <= cur_addr + 12'h001;
              wr_stb <= !rd_mode;
              wr_addr <= cur_addr;
              wr_data <= {wdata_sr, spi_sdi_in};
            end
          end
          default: phase <= dac_ctrl_pkg::PH_IDLE;
        endcase
      end
    end
  end

  // Readback shifter and data out, driven only in four-wire mode
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_sr <= '0;
      spi_sdo_out <= 1'b0;
      spi_sdo_oe_n_out <= 1'b1;
    end else begin
      if (sclk_rise && phase == dac_ctrl_pkg::PH_INSTR && bit_cnt == dac_ctrl_pkg::INSTR_LAST) begin
        rdata_sr <= read_reg(full_instr[11:0]);
      end else if (sclk_rise && phase == dac_ctrl_pkg::PH_DATA && bit_cnt == dac_ctrl_pkg::DATA_LAST) begin
        rdata_sr <= read_reg(cur_addr + 12'h001);
      end else if (sclk_fall && phase == dac_ctrl_pkg::PH_DATA && rd_mode) begin
        spi_sdo_out <= rdata_sr[7];
        rdata_sr <= {rdata_sr[6:0], 1'b0};
      end
      spi_sdo_oe_n_out <= !(four_wire && rd_mode && phase == dac_ctrl_pkg::PH_DATA && !spi_cs_n_in);
    end
  end

  // Interface configuration survives its own soft reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      iface_cfg <= dac_ctrl_pkg::RST_IFACE;
    end else if (wr_stb && wr_addr == dac_ctrl_pkg::A_IFACE) begin
      iface_cfg <= wr_data; // R11
    end
  end

  // Control registers, held at defaults during soft reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      power_ctl <= dac_ctrl_pkg::RST_POWER;
      mode_sel <= dac_ctrl_pkg::RST_MODE;
      clk_pwr <= dac_ctrl_pkg::RST_CLKPWR;
      trx_ctl <= dac_ctrl_pkg::RST_TRX;
      dp_cfg_a <= dac_ctrl_pkg::RST_ZERO;
      dp_cfg_b <= dac_ctrl_pkg::RST_ZERO;
      link_cfg <= dac_ctrl_pkg::RST_ZERO;
      temp_en <= dac_ctrl_pkg::RST_ZERO;
    end else if (soft_rst) begin
      power_ctl <= dac_ctrl_pkg::RST_POWER;
      mode_sel <= dac_ctrl_pkg::RST_MODE; // R1
      clk_pwr <= dac_ctrl_pkg::RST_CLKPWR;
      trx_ctl <= dac_ctrl_pkg::RST_TRX;
      dp_cfg_a <= dac_ctrl_pkg::RST_ZERO;
      dp_cfg_b <= dac_ctrl_pkg::RST_ZERO;
      link_cfg <= dac_ctrl_pkg::RST_ZERO;
      temp_en <= dac_ctrl_pkg::RST_ZERO;
    end else if (wr_stb) begin
      unique case (wr_addr)
        dac_ctrl_pkg::A_POWER: power_ctl <= wr_data;
        dac_ctrl_pkg::A_MODE: mode_sel <= wr_data; // R1
        dac_ctrl_pkg::A_CLKPWR: clk_pwr <= wr_data;
        dac_ctrl_pkg::A_TRX: trx_ctl <= wr_data;
        dac_ctrl_pkg::A_DPA: dp_cfg_a <= wr_data;
        dac_ctrl_pkg::A_DPB: dp_cfg_b <= wr_data;
        dac_ctrl_pkg::A_LINK: link_cfg <= wr_data;
        dac_ctrl_pkg::A_TEMP_EN: temp_en <= wr_data;
        default: power_ctl <= power_ctl;
      endcase
    end
  end

  // Temperature capture; sensor must be enabled to refresh
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      temp_code <= '0;
    end else if (wr_stb && wr_addr == dac_ctrl_pkg::A_CAPTURE && wr_data[dac_ctrl_pkg::B_CAPTURE]
                 && temp_en[dac_ctrl_pkg::B_TEMP_EN] && !soft_rst) begin
      temp_code <= temp_sensor_in; // R10
    end
  end

  // Decoded pin controls
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      soft_reset_out <= 1'b0;
      reference_enable_out <= 1'b0;
      master_enable_out <= 1'b0;
      core_enable_out <= '0;
      clocks_enable_out <= 1'b0;
      duty_correction_out <= 1'b0;
      timing_rx_enable_out <= 1'b0;
      timing_rx_hysteresis_out <= 1'b0;
      temp_sensor_enable_out <= 1'b0;
      mix_mode_out <= 1'b0;
    end else begin
      soft_reset_out <= soft_rst; // R11
      reference_enable_out <= !power_ctl[dac_ctrl_pkg::B_PD_REF]; // R12
      master_enable_out <= !power_ctl[dac_ctrl_pkg::B_PD_MASTER]; // R12
      core_enable_out <= ~power_ctl[dac_ctrl_pkg::B_PD_CORE0 +: 4]; // R12
      clocks_enable_out <= !clk_pwr[dac_ctrl_pkg::B_CLK_PD]
                           && (clk_pwr & dac_ctrl_pkg::CLK_OTHER_MASK) == 8'h00; // R13
      duty_correction_out <= clk_pwr[dac_ctrl_pkg::B_DCC]; // R13
      timing_rx_enable_out <= !trx_ctl[dac_ctrl_pkg::B_TRX_PD]; // R14
      timing_rx_hysteresis_out <= trx_ctl[dac_ctrl_pkg::B_TRX_HYST]; // R14
      temp_sensor_enable_out <= temp_en[dac_ctrl_pkg::B_TEMP_EN];
      mix_mode_out <= mode_sel[dac_ctrl_pkg::B_MIX]; // R2
    end
  end

  // Stream drains only with master and clocks up
  assign running = !soft_rst && !power_ctl[dac_ctrl_pkg::B_PD_MASTER]
                   && !clk_pwr[dac_ctrl_pkg::B_CLK_PD]
                   && ((clk_pwr & dac_ctrl_pkg::CLK_OTHER_MASK) == 8'h00);

  sample_fifo #(
    .WIDTH(dac_ctrl_pkg::CORES * dac_ctrl_pkg::CODE_W),
    .DEPTH(dac_ctrl_pkg::FIFO_DEPTH)
  ) sample_fifo_inst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .flush_in(soft_rst),
    .in_data_in(core_input_code_in),
    .in_valid_in(sample_valid_in),
    .in_ready_out(sample_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(running)
  );

  // Per-core half-cycle codes and gains; even cores in-phase, odd quadrature
  for (genvar i = 0; i < dac_ctrl_pkg::CORES; i++) begin : g_core
    logic [15:0] code;
    assign code = power_ctl[dac_ctrl_pkg::B_PD_CORE0 + i] ? 16'h0000 : fifo_data[16*i +: 16];
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        rise_code_out[16*i +: 16] <= 16'h0000;
        fall_code_out[16*i +: 16] <= 16'h0000;
        rise_comp_out[16*i +: 16] <= 16'hffff;
        fall_comp_out[16*i +: 16] <= 16'hffff;
      end else if (running && fifo_valid) begin
        rise_code_out[16*i +: 16] <= code; // R5
        rise_comp_out[16*i +: 16] <= ~code; // R6
        if (mode_sel[dac_ctrl_pkg::B_MIX]) begin
          fall_code_out[16*i +: 16] <= ~code; // R4
          fall_comp_out[16*i +: 16] <= code; // R6
        end else begin
          fall_code_out[16*i +: 16] <= code; // R3
          fall_comp_out[16*i +: 16] <= ~code; // R6
        end
      end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        core_gain_out[8*i +: 8] <= dac_ctrl_pkg::RST_GAIN;
      end else begin
        core_gain_out[8*i +: 8] <= gain_word[i]; // R8
      end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        gain_word[i] <= dac_ctrl_pkg::RST_GAIN;
      end else if (soft_rst) begin
        gain_word[i] <= dac_ctrl_pkg::RST_GAIN;
      end else if (wr_stb && wr_addr == dac_ctrl_pkg::A_GAIN0 + 12'(i)) begin
        gain_word[i] <= wr_data; // R8
      end
    end
  end

  // Checks
  sequence s_wr(logic [11:0] a, logic [7:0] d);
    wr_stb && wr_addr == a && wr_data == d;
  endsequence
  sequence s_soft_enter;
    s_wr(dac_ctrl_pkg::A_IFACE, 8'hbd);
  endsequence
  sequence s_soft_leave;
    s_wr(dac_ctrl_pkg::A_IFACE, 8'h3c);
  endsequence

  a_mode_default: assert property (@(posedge clk_in) disable iff (rst_in) // R1
    soft_rst |-> ##2 !mix_mode_out) else $error("mode not normal after soft reset");
  a_mode_decode: assert property (@(posedge clk_in) disable iff (rst_in) // R2
    wr_stb && wr_addr == dac_ctrl_pkg::A_MODE && !soft_rst |-> ##2 mix_mode_out == $past(wr_data[0], 2))
    else $error("mode bit not decoded");
  a_normal_repeat: assert property (@(posedge clk_in) disable iff (rst_in) // R3
    running && fifo_valid && !mode_sel[0] |=> fall_code_out == rise_code_out)
    else $error("normal mode halves differ");
  a_mix_invert: assert property (@(posedge clk_in) disable iff (rst_in) // R4
    running && fifo_valid && mode_sel[0] |=> fall_code_out == ~rise_code_out)
    else $error("mix mode second half not inverse");
  a_stream_load: assert property (@(posedge clk_in) disable iff (rst_in) // R5
    running && fifo_valid && power_ctl[6:3] == 4'h0 |=> rise_code_out == $past(fifo_data))
    else $error("sample not presented");
  a_comp_pair: assert property (@(posedge clk_in) disable iff (rst_in) // R6
    rise_comp_out == ~rise_code_out && fall_comp_out == ~fall_code_out)
    else $error("outputs not complementary");
  a_gain_apply: assert property (@(posedge clk_in) disable iff (rst_in) // R8
    wr_stb && wr_addr == dac_ctrl_pkg::A_GAIN2 && !soft_rst |-> ##2 core_gain_out[23:16] == $past(wr_data, 2))
    else $error("gain not applied");
  a_capture_fresh: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    wr_stb && wr_addr == dac_ctrl_pkg::A_CAPTURE && wr_data[0] && temp_en[0] && !soft_rst
    |=> temp_code == $past(temp_sensor_in)) else $error("temperature not captured");
  a_soft_cycle: assert property (@(posedge clk_in) disable iff (rst_in) // R11
    s_soft_enter ##1 (!wr_stb)[*1] |-> ##1 soft_reset_out) else $error("soft reset not entered");
  a_soft_release: assert property (@(posedge clk_in) disable iff (rst_in) // R11
    s_soft_leave |-> ##2 !soft_reset_out) else $error("soft reset not released");
  a_power_up: assert property (@(posedge clk_in) disable iff (rst_in) // R12
    s_wr(dac_ctrl_pkg::A_POWER, 8'h00) ##0 !soft_rst |-> ##2 reference_enable_out && master_enable_out
    && core_enable_out == 4'hf) else $error("power up incomplete");
  a_clock_power: assert property (@(posedge clk_in) disable iff (rst_in) // R13
    s_wr(dac_ctrl_pkg::A_CLKPWR, 8'h04) ##0 !soft_rst |-> ##2 clocks_enable_out && duty_correction_out)
    else $error("clocks not powered");
  a_timing_rx: assert property (@(posedge clk_in) disable iff (rst_in) // R14
    s_wr(dac_ctrl_pkg::A_TRX, 8'h00) ##0 !soft_rst |-> ##2 timing_rx_enable_out && !timing_rx_hysteresis_out)
    else $error("timing receiver not powered");
endmodule

// file: tb/spi_host_model.sv
// Serial configuration host driving the converter control block
`timescale 1ns/100ps
module spi_host_model (
  // Clock
  input wire logic clk_in,
  // Serial port
  output logic spi_cs_n_out,
  output logic spi_clk_out,
  output logic spi_sdi_out,
  input wire logic spi_sdo_in,
  input wire logic spi_sdo_oe_n_in
);
  initial begin
    spi_cs_n_out = 1'b1;
    spi_clk_out = 1'b0;
    spi_sdi_out = 1'b0;
  end
  // One serial clock pulse, four sample clocks per phase; sdo read only while driven
  task automatic pulse(input logic b, output logic q);
    spi_sdi_out = b;
    repeat (4) @(negedge clk_in);
    q = (spi_sdo_oe_n_in === 1'b0) ? spi_sdo_in : 1'bx;
    spi_clk_out = 1'b1;
    repeat (4) @(negedge clk_in);
    spi_clk_out = 1'b0;
  endtask
  // Whole frame: instruction then one data byte; chip select rises between frames
  task automatic xfer(input logic rd, input logic [11:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] instr;
    logic q;
    instr = {rd, 3'b000, addr};
    spi_cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) pulse(instr[i], q);
    for (int i = 7; i >= 0; i--) begin
      pulse(wd[i], q);
      rdat[i] = q;
    end
    repeat (4) @(negedge clk_in);
    spi_cs_n_out = 1'b1;
    spi_sdi_out = ~spi_sdi_out;
    repeat (6) @(negedge clk_in);
  endtask
endmodule

// file: tb/quad_dac_output_control_test.sv
// Self-checking bench for the quad converter output control block
`timescale 1ns/100ps
module quad_dac_output_control_test;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cs_n, sclk, sdi, sdo, sdo_oe_n, sample_valid_in, sample_ready_out, temp_sensor_enable_out, mix_mode_out;
  logic [63:0] core_input_code_in = 64'h0;
  logic [15:0] temp_sensor_in = 16'h1234;
  logic [63:0] rise_code_out, fall_code_out, rise_comp_out, fall_comp_out;
  logic [31:0] core_gain_out;
  logic soft_reset_out, reference_enable_out, master_enable_out, clocks_enable_out, duty_correction_out;
  logic timing_rx_enable_out, timing_rx_hysteresis_out;
  logic [3:0] core_enable_out;
  int mismatches = 0;
  int compares = 0;
  initial sample_valid_in = 1'b0;
  always #2.5 clk_in = ~clk_in;
  quad_dac_output_control quad_dac_output_control_inst (.clk_in(clk_in), .rst_in(rst_in),
    .spi_cs_n_in(cs_n), .spi_clk_in(sclk), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_n_out(sdo_oe_n),
    .core_input_code_in(core_input_code_in), .sample_valid_in(sample_valid_in),
    .sample_ready_out(sample_ready_out), .temp_sensor_in(temp_sensor_in),
    .temp_sensor_enable_out(temp_sensor_enable_out), .rise_code_out(rise_code_out),
    .fall_code_out(fall_code_out), .rise_comp_out(rise_comp_out), .fall_comp_out(fall_comp_out),
    .core_gain_out(core_gain_out), .mix_mode_out(mix_mode_out), .soft_reset_out(soft_reset_out),
    .reference_enable_out(reference_enable_out), .master_enable_out(master_enable_out),
    .core_enable_out(core_enable_out), .clocks_enable_out(clocks_enable_out),
    .duty_correction_out(duty_correction_out), .timing_rx_enable_out(timing_rx_enable_out),
    .timing_rx_hysteresis_out(timing_rx_hysteresis_out));
  spi_host_model host_inst (.clk_in(clk_in), .spi_cs_n_out(cs_n), .spi_clk_out(sclk), .spi_sdi_out(sdi),
    .spi_sdo_in(sdo), .spi_sdo_oe_n_in(sdo_oe_n));
  task automatic test_done();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host_inst.xfer(1'b0, a, d, unused);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host_inst.xfer(1'b1, a, 8'h00, q);
    chk(q, exp, "register read");
  endtask
  task automatic push(input logic [63:0] w);
    int n;
    for (n = 0; n < 60 && sample_ready_out !== 1'b1; n++) @(negedge clk_in);
    if (n == 60) begin
      mismatches++;
      $display("CHECK FAILED at %0t: sample input never ready", $time);
      test_done();
    end
    core_input_code_in = w;
    sample_valid_in = 1'b1;
    @(negedge clk_in);
  endtask
  task automatic wait_out(input logic [63:0] w);
    int n;
    for (n = 0; n < 60 && rise_code_out !== w; n++) @(negedge clk_in);
    if (n == 60) begin
      mismatches++;
      $display("CHECK FAILED at %0t: sample never reached output", $time);
      test_done();
    end
  endtask
  task automatic t_reset();
    chk(mix_mode_out, 1'b0, "mode after reset");
    chk({reference_enable_out, master_enable_out, clocks_enable_out}, 3'b000, "power after reset");
  endtask
  task automatic t_startup();
    wr(dac_ctrl_pkg::A_IFACE, 8'hbd);
    chk({soft_reset_out, sample_ready_out}, 2'b10, "soft reset entry");
    wr(dac_ctrl_pkg::A_IFACE, 8'h3c);
    chk(soft_reset_out, 1'b0, "soft reset release");
    wr(dac_ctrl_pkg::A_POWER, 8'h00);
    chk({reference_enable_out, master_enable_out, core_enable_out}, 6'h3f, "power up");
    wr(dac_ctrl_pkg::A_CLKPWR, 8'h04);
    chk({clocks_enable_out, duty_correction_out}, 2'b11, "clocks up");
    wr(dac_ctrl_pkg::A_TRX, 8'h00);
    chk({timing_rx_enable_out, timing_rx_hysteresis_out}, 2'b10, "timing receiver");
    wr(dac_ctrl_pkg::A_DPA, 8'h8b);
    wr(dac_ctrl_pkg::A_DPB, 8'h01);
    wr(dac_ctrl_pkg::A_LINK, 8'h01);
    rd_chk(dac_ctrl_pkg::A_DPA, 8'h8b);
    rd_chk(dac_ctrl_pkg::A_LINK, 8'h01);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 4; i++) wr(12'(dac_ctrl_pkg::A_GAIN0 + i), 8'(8'h11 * (i + 1)));
    chk(core_gain_out, 32'h44332211, "gain words");
    rd_chk(dac_ctrl_pkg::A_GAIN2, 8'h33);
    rd_chk(12'h123, 8'h00);
    wr(dac_ctrl_pkg::A_TEMP_LO, 8'h5a);
    rd_chk(dac_ctrl_pkg::A_TEMP_LO, 8'h00);
  endtask
  task automatic t_normal();
    logic [63:0] w0, w1;
    w0 = 64'hffff_0000_8001_7ffe;
    w1 = 64'h0123_4567_89ab_cdef;
    push(w0);
    push(w1);
    sample_valid_in = 1'b0;
    wait_out(w0);
    chk(fall_code_out, w0, "normal second half");
    chk({rise_comp_out, fall_comp_out}, {~w0, ~w0}, "negative outputs");
    @(negedge clk_in);
    chk({rise_code_out, fall_code_out}, {w1, w1}, "back to back sample");
  endtask
  task automatic t_mix();
    logic [63:0] w;
    w = 64'h00ff_1234_fedc_8000;
    wr(dac_ctrl_pkg::A_MODE, 8'h01);
    chk(mix_mode_out, 1'b1, "mix mode select");
    rd_chk(dac_ctrl_pkg::A_MODE, 8'h01);
    push(w);
    sample_valid_in = 1'b0;
    wait_out(w);
    chk({fall_code_out, fall_comp_out}, {~w, w}, "mix inverse half");
    wr(dac_ctrl_pkg::A_MODE, 8'h00);
    chk(mix_mode_out, 1'b0, "normal mode select");
  endtask
  task automatic t_fifo();
    int n;
    wr(dac_ctrl_pkg::A_POWER, 8'h04);
    n = 0;
    while (sample_ready_out === 1'b1 && n < 40) begin
      core_input_code_in = {4{n[15:0]}};
      sample_valid_in = 1'b1;
      n++;
      @(negedge clk_in);
    end
    sample_valid_in = 1'b0;
    chk(n, dac_ctrl_pkg::FIFO_DEPTH, "buffer depth");
    wr(dac_ctrl_pkg::A_POWER, 8'h00);
    wait_out({4{16'h001f}});
    chk(sample_ready_out, 1'b1, "buffer drained");
  endtask
  task automatic t_temp();
    wr(dac_ctrl_pkg::A_TEMP_EN, 8'h01);
    chk(temp_sensor_enable_out, 1'b1, "sensor enable");
    wr(dac_ctrl_pkg::A_CAPTURE, 8'h01);
    temp_sensor_in = 16'h5678;
    rd_chk(dac_ctrl_pkg::A_TEMP_LO, 8'h34);
    rd_chk(dac_ctrl_pkg::A_TEMP_HI, 8'h12);
    rd_chk(dac_ctrl_pkg::A_CAPTURE, 8'h00);
    wr(dac_ctrl_pkg::A_CAPTURE, 8'h01);
    rd_chk(dac_ctrl_pkg::A_TEMP_HI, 8'h56);
  endtask
  task automatic t_soft();
    wr(dac_ctrl_pkg::A_IFACE, 8'hbd);
    chk(core_gain_out, 32'h0, "gains in soft reset");
    wr(dac_ctrl_pkg::A_GAIN0, 8'h77);
    wr(dac_ctrl_pkg::A_IFACE, 8'h3c);
    rd_chk(dac_ctrl_pkg::A_GAIN0, 8'h00);
    chk(reference_enable_out, 1'b0, "power after soft reset");
    temp_sensor_in = 16'h9abc;
    wr(dac_ctrl_pkg::A_CAPTURE, 8'h01);
    rd_chk(dac_ctrl_pkg::A_TEMP_LO, 8'h78);
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    t_reset();
    t_startup();
    t_regs();
    t_normal();
    t_mix();
    t_fifo();
    t_temp();
    t_soft();
    test_done();
  end
endmodule
